// ---- core/processor_io_bus_channel_port.sv ----
// device end of the processor i/o bus for one transfer controller
`timescale 1ns/10ps
`default_nettype none

// Operation
// - select values are 3-of-6 codes; other patterns never select anything.
// - channels 10..19 are transfer controllers; 00..09 belong to add-on slots.
// - add-on slot codes 07,0B,0D,0E,13 and 15,16,19,1A,1C are never answered.
// - controller zero answers 23 for itself, 25,26,29,2A for channels.
// - controller one answers 2C for itself, 31,32,34,38 for channels.
// - any single-hot operation pulse (not bit 06) to a selected controller echoes its own select code.
// - fault line is OR of controller error and its four channel errors.
// - health line means no error present; processor records its failure.
// - buffer read raises ready once data is on bus; channel irq/svc/idle/clear never; state read once the bus is quiet; others immediately.
// - pulse bits 00..05 and 07..10 encode the ten bus operations.
// - controller select answers all; channel irq/svc/idle/clear give echo plus request.
// - control/address write answers fully and always raises a microcode request.
// - buffer and state read pulses withhold ready while the bus busy condition is set.
// - channel read returns health only when that channel is healthy.
// - two interrupt summary lines per controller, one per channel pair.
// - 32-bit data lines carry read and write data for the selection.
// - each data byte has even parity, checked on processor writes.
module processor_io_bus_channel_port
  import io_port_pkg::*;
#(
  parameter logic [5:0] CTRL_CODE   = io_port_pkg::SEL_CTRL0,
  parameter logic [5:0] CH_CODE0    = io_port_pkg::SEL_C0CH0,
  parameter logic [5:0] CH_CODE1    = io_port_pkg::SEL_C0CH1,
  parameter logic [5:0] CH_CODE2    = io_port_pkg::SEL_C0CH2,
  parameter logic [5:0] CH_CODE3    = io_port_pkg::SEL_C0CH3
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic [5:0]               io_select_lines,
  input  wire logic [10:0]              pulse_vec,
  input  wire logic                     io_inhibit,
  input  wire logic [31:0]              io_data_in,
  input  wire logic [3:0]               io_parity_in,
  output logic      [31:0]              io_data_out,
  output logic      [3:0]               io_parity_out,
  output logic                          io_data_oe,
  output io_port_pkg::resp_t            resp,
  input  wire logic                     ctrl_error,
  input  wire logic [3:0]               ch_error,
  input  wire logic [3:0]               ch_health,
  input  wire logic                     bus_busy,
  input  wire logic [3:0]               ch_irq,
  input  wire logic                     read_data_valid,
  input  wire logic [31:0]              read_data,
  output io_port_pkg::micro_req_t       micro
);
  import io_port_pkg::*;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // a select is only valid with exactly three bits set
  function automatic logic weight_ok(input logic [5:0] c);
    return ($countones(c) == CODE_WEIGHT);
  endfunction

  // one-hot channel match to its index; no match reads as channel 0
  function automatic logic [1:0] ch_index(input logic [3:0] s);
    return s[3] ? 2'd3 : s[2] ? 2'd2 : s[1] ? 2'd1 : 2'd0;
  endfunction

  // per-byte even parity: the parity bit makes each byte's count even
  function automatic logic [3:0] even_par(input logic [31:0] d);
    logic [3:0] p;
    for (int i = 0; i < 4; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // idle, read waiting for data or a quiet bus, response standing
  typedef enum {S_IDLE, S_WAIT_DATA, S_HOLD} phase_t;

  // everything the port remembers, registered as one word
  typedef struct packed {
    phase_t      phase;
    logic [31:0] dout;
    logic [3:0]  pout;
    logic        doe;
    resp_t       rsp;
    micro_req_t  mreq;
    logic [10:0] prev_pulse;
  } state_t;

  state_t cur;
  state_t next_state;

  // ---------------------------------------------------------------
  // select and pulse decode
  // ---------------------------------------------------------------
  logic        sel_self;
  logic [3:0]  sel_ch;
  logic        hit;
  logic [10:0] rise;
  logic        any_pulse;
  logic        rd_pulse;
  logic        chan_pio_op;

  // address decode: slot codes and non-weight-3 patterns never hit
  always_comb begin
    sel_self = weight_ok(io_select_lines) && (io_select_lines == CTRL_CODE);
    sel_ch[0] = weight_ok(io_select_lines) && (io_select_lines == CH_CODE0);
    sel_ch[1] = weight_ok(io_select_lines) && (io_select_lines == CH_CODE1);
    sel_ch[2] = weight_ok(io_select_lines) && (io_select_lines == CH_CODE2);
    sel_ch[3] = weight_ok(io_select_lines) && (io_select_lines == CH_CODE3);
    hit = (sel_self | (|sel_ch)) && !io_inhibit;
  end

  // pulse edge detect; only a single-hot pulse is served
  always_comb begin
    rise = pulse_vec & ~cur.prev_pulse;
    any_pulse = hit && ($countones(rise) == 1) && !rise[P_UNUSED6];
    rd_pulse = rise[P_READ_BUF] | rise[P_READ_STATE];
    chan_pio_op = rise[P_READ_IRQ] | rise[P_READ_SVC] | rise[P_IDLE_SEQ] | rise[P_CLR_FAULT];
  end

  // ---------------------------------------------------------------
  // response sequencing
  // ---------------------------------------------------------------
  // responses stand until the pulse line drops, which keeps them
  // valid for however long the processor samples
  always_comb begin
    next_state = cur;
    next_state.prev_pulse = pulse_vec;
    next_state.mreq.pio_req = 1'b0;
    next_state.mreq.parity_err = 1'b0;
    // fault summary and interrupts are live levels, registered
    next_state.rsp.fault = ctrl_error | (|ch_error);
    next_state.rsp.irq = {|ch_irq[3:2], |ch_irq[1:0]};
    unique case (cur.phase)
      // take a new single-hot pulse only from rest
      S_IDLE: begin
        if (any_pulse) begin
          next_state.rsp.echo = CTRL_CODE;
          next_state.rsp.echo_oe = 1'b1;
          next_state.mreq.op = rise;
          next_state.mreq.target_self = sel_self;
          next_state.mreq.target_ch = ch_index(sel_ch);
          next_state.mreq.wdata = io_data_in;
          if (rise[P_WRITE_CA] || rise[P_WRITE_BUF]) begin
            next_state.mreq.parity_err = (even_par(io_data_in) != io_parity_in);
          end
          if (rise[P_WRITE_CA]) begin
            next_state.mreq.pio_req = 1'b1;
          end
          if (!sel_self && chan_pio_op) begin
            // channel-side op: echo only, microcode finishes it
            next_state.mreq.pio_req = 1'b1;
            next_state.rsp.health_ok = 1'b0;
            next_state.rsp.ready = 1'b0;
            next_state.phase = S_HOLD;
          end else begin
            // health: no error, and for channel reads the channel's own health
            next_state.rsp.health_ok = !next_state.rsp.fault &&
              (sel_self || !rd_pulse || |(sel_ch & ch_health));
            if (rise[P_READ_BUF] || (rd_pulse && bus_busy)) begin
              next_state.rsp.ready = 1'b0;
              next_state.phase = S_WAIT_DATA;
            end else begin
              next_state.rsp.ready = 1'b1;
              next_state.phase = S_HOLD;
            end
          end
        end
      end
      // hold ready low until the data and the bus allow it
      S_WAIT_DATA: begin
        if (pulse_vec == '0) begin
          next_state.phase = S_IDLE;
          next_state.rsp.echo_oe = 1'b0;
          next_state.rsp.health_ok = 1'b0;
        end else if (!bus_busy && (!cur.mreq.op[P_READ_BUF] || read_data_valid)) begin
          next_state.dout = read_data;
          next_state.pout = even_par(read_data);
          next_state.doe = cur.mreq.op[P_READ_BUF];
          next_state.rsp.ready = 1'b1;
          next_state.phase = S_HOLD;
        end
      end
      // responses stand until the processor drops its pulse
      S_HOLD: begin
        if (pulse_vec == '0) begin
          next_state.phase = S_IDLE;
          next_state.rsp.ready = 1'b0;
          next_state.rsp.health_ok = 1'b0;
          next_state.rsp.echo_oe = 1'b0;
          next_state.doe = 1'b0;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // register the whole state; reset puts every output at rest
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '{phase: S_IDLE, default: '0};
    end else begin
      cur <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // data and parity come straight from flops, no decode on the pins
  assign io_data_out   = cur.dout;
  assign io_parity_out = cur.pout;
  assign io_data_oe    = cur.doe;
  assign resp          = cur.rsp;
  assign micro         = cur.mreq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // echo and select decode
  chk_echo_code: assert property (resp.echo_oe |-> resp.echo == CTRL_CODE && weight_ok(resp.echo))
    else $error("echo not own code");
  chk_weight_only: assert property (any_pulse |-> weight_ok(io_select_lines))
    else $error("pulse taken on invalid select");
  chk_ignore_miss: assert property (cur.phase == S_IDLE && !hit |=> !resp.echo_oe && !resp.ready)
    else $error("responded to foreign select");
  chk_slot_silent: assert property (cur.phase == S_IDLE && !io_select_lines[5] |=> !resp.echo_oe)
    else $error("responded to add-on slot code");
  chk_inhibit_quiet: assert property (cur.phase == S_IDLE && io_inhibit |=> !resp.echo_oe)
    else $error("responded while inhibited");

  // status summaries
  chk_fault_or: assert property (resp.fault == $past(ctrl_error | (|ch_error)))
    else $error("fault summary wrong");
  chk_irq_sum: assert property (resp.irq == $past({|ch_irq[3:2], |ch_irq[1:0]}))
    else $error("irq summary wrong");
  chk_health_fault: assert property ($rose(resp.echo_oe) && resp.fault |-> !resp.health_ok)
    else $error("health with fault present");

  // ready timing; a missed release would hold the processor
  chk_ready_now: assert property (any_pulse && cur.phase == S_IDLE && !rd_pulse
                                  && !(chan_pio_op && !sel_self) |=> resp.ready && resp.echo_oe)
    else $error("ready not immediate");
  chk_ready_busy: assert property (cur.phase == S_WAIT_DATA && bus_busy |=> !resp.ready)
    else $error("ready during busy");
  chk_busy_entry: assert property (any_pulse && cur.phase == S_IDLE && rd_pulse && bus_busy
                                   |=> !resp.ready && resp.echo_oe)
    else $error("read ready while bus busy");
  chk_release: assert property (cur.phase != S_IDLE && pulse_vec == '0
                                |=> !resp.echo_oe && !resp.ready && !io_data_oe)
    else $error("response outlived pulse");
  chk_resp_stand: assert property (resp.echo_oe && pulse_vec != '0 |=> resp.echo_oe)
    else $error("echo dropped early");

  // read data path
  chk_read_data: assert property ($past(cur.phase) == S_WAIT_DATA && $rose(resp.ready) && io_data_oe
                                  |-> io_data_out == $past(read_data))
    else $error("read data not placed");
  chk_doe_read: assert property (io_data_oe |-> micro.op[P_READ_BUF] && resp.ready)
    else $error("data driven outside a buffer read");

  // microcode requests
  chk_chan_pio: assert property (any_pulse && cur.phase == S_IDLE && !sel_self && chan_pio_op
                                 |=> micro.pio_req && !resp.ready && !resp.health_ok)
    else $error("channel op response wrong");
  chk_self_full: assert property (any_pulse && cur.phase == S_IDLE && sel_self && !rd_pulse
                                  |=> resp.ready && resp.echo_oe && resp.health_ok == !resp.fault)
    else $error("controller op response wrong");
  chk_wca_pio: assert property (any_pulse && cur.phase == S_IDLE && rise[P_WRITE_CA]
                                |=> micro.pio_req ##1 !micro.pio_req)
    else $error("control write request wrong");
  chk_pio_single: assert property (micro.pio_req |=> !micro.pio_req)
    else $error("request longer than one cycle");

  // channel health and write parity
  chk_chan_health: assert property (any_pulse && cur.phase == S_IDLE && !sel_self && rd_pulse
                                    && !(|(sel_ch & ch_health)) |=> !resp.health_ok)
    else $error("health on sick channel");
  chk_parity: assert property (any_pulse && cur.phase == S_IDLE && rise[P_WRITE_BUF]
                               && (even_par(io_data_in) != io_parity_in) |=> micro.parity_err)
    else $error("parity miss");

  // main scenarios reached
  cov_self_read:  cover property (sel_self && rise[P_READ_STATE] ##1 resp.ready);
  cov_chan_read:  cover property (rise[P_READ_BUF] && hit ##[1:20] io_data_oe);
  cov_chan_pio:   cover property (micro.pio_req && !micro.target_self);
  cov_busy_wait:  cover property (cur.phase == S_WAIT_DATA && bus_busy ##1 resp.ready);
  cov_ctrl_write: cover property (rise[P_WRITE_CA] && hit ##1 micro.pio_req);

endmodule

`default_nettype wire

// ---- core/io_port_pkg.sv ----
// package: select codes, pulse positions and shared carriers for the i/o bus port
package io_port_pkg;

  // ---------------------------------------------------------------
  // select codes (3-out-of-6)
  // ---------------------------------------------------------------
  localparam logic [5:0] SEL_CTRL0 = 6'h23;
  localparam logic [5:0] SEL_C0CH0 = 6'h25;
  localparam logic [5:0] SEL_C0CH1 = 6'h26;
  localparam logic [5:0] SEL_C0CH2 = 6'h29;
  localparam logic [5:0] SEL_C0CH3 = 6'h2A;
  localparam logic [5:0] SEL_CTRL1 = 6'h2C;
  localparam logic [5:0] SEL_C1CH0 = 6'h31;
  localparam logic [5:0] SEL_C1CH1 = 6'h32;
  localparam logic [5:0] SEL_C1CH2 = 6'h34;
  localparam logic [5:0] SEL_C1CH3 = 6'h38;
  // add-on slot codes, never answered here
  localparam logic [5:0] SEL_SLOT0_LO = 6'h07;
  localparam logic [5:0] SEL_SLOT0_HI = 6'h13;
  localparam logic [5:0] SEL_SLOT1_LO = 6'h15;
  localparam logic [5:0] SEL_SLOT1_HI = 6'h1C;
  localparam int         CODE_WEIGHT  = 3;
  localparam int         NUM_CH       = 4;

  // ---------------------------------------------------------------
  // pulse bit positions within the 11-bit pulse vector
  // ---------------------------------------------------------------
  localparam int P_READ_BUF   = 0;
  localparam int P_READ_STATE = 1;
  localparam int P_READ_IRQ   = 2;
  localparam int P_READ_SVC   = 3;
  localparam int P_IRQ_ACK    = 4;
  localparam int P_FAULT_ACK  = 5;
  localparam int P_UNUSED6    = 6;
  localparam int P_IDLE_SEQ   = 7;
  localparam int P_CLR_FAULT  = 8;
  localparam int P_WRITE_BUF  = 9;
  localparam int P_WRITE_CA   = 10;
  localparam int NUM_PULSE    = 11;

  // responses toward the processor
  typedef struct packed {
    logic [5:0] echo;
    logic       echo_oe;
    logic       ready;
    logic       health_ok;
    logic       fault;
    logic [1:0] irq;
  } resp_t;

  // requests toward the controller microcode
  typedef struct packed {
    logic        pio_req;
    logic        target_self;
    logic [1:0]  target_ch;
    logic [10:0] op;
    logic [31:0] wdata;
    logic        parity_err;
  } micro_req_t;

endpackage

// ---- tb/cpu_model.sv ----
// processor-side model: select code, control pulses, inhibit and write data
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
  input  wire logic        clk,
  output logic [5:0]       io_select_lines,
  output logic [10:0]      pulse_vec,
  output logic             io_inhibit,
  output var logic [31:0]  io_data_in,
  output var logic [3:0]   io_parity_in
);
  logic [31:0] hardware_state_word = '0;
  logic [10:0] pulse_point_word    = '0;
  logic [31:0] system_state_word   = '0;

  // ---------------------------------
  // pins follow the processor words
  // ---------------------------------
  assign io_select_lines = hardware_state_word[15:10];
  assign pulse_vec       = pulse_point_word;
  assign io_inhibit      = system_state_word[9] | system_state_word[30];

  initial begin
    io_data_in = '0;
    io_parity_in = '0;
  end

  // start one operation just after a falling edge
  task automatic issue(input logic [5:0] s, input logic [10:0] p, input logic [31:0] d, input logic [3:0] q);
    @(negedge clk);
    hardware_state_word[15:10] = s;
    pulse_point_word = p;
    io_data_in = d;
    io_parity_in = q;
  endtask

  // released lines show the inverse so a stale value never passes
  task automatic drop();
    @(negedge clk);
    pulse_point_word = '0;
    hardware_state_word[15:10] = ~hardware_state_word[15:10];
    io_data_in = ~io_data_in;
    io_parity_in = ~io_parity_in;
    repeat (2) @(negedge clk);
  endtask

  task automatic set_inhibit(input logic on);
    @(negedge clk);
    system_state_word[30] = on;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the device end of the processor i/o bus
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import io_port_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [5:0]  sel;
  logic [10:0] pv;
  logic        inh;
  logic [31:0] din, dout;
  logic [31:0] rdata = 32'h0;
  logic [3:0]  pin, pout;
  logic [3:0]  ch_error = 4'h0, ch_health = 4'hF, ch_irq = 4'h0;
  logic        doe;
  logic        ctrl_error = 1'b0, bus_busy = 1'b0, rvalid = 1'b1;
  resp_t       resp;
  micro_req_t  micro;
  int          n_errors = 0;
  int          compares = 0;
  int          npio = 0;
  int          nperr = 0;

  always #20 clk = ~clk;

  cpu_model i_cpu_model (.clk(clk), .io_select_lines(sel), .pulse_vec(pv), .io_inhibit(inh),
    .io_data_in(din), .io_parity_in(pin));
  processor_io_bus_channel_port i_processor_io_bus_channel_port (.clk(clk), .resetn(resetn),
    .io_select_lines(sel), .pulse_vec(pv), .io_inhibit(inh), .io_data_in(din), .io_parity_in(pin),
    .io_data_out(dout), .io_parity_out(pout), .io_data_oe(doe), .resp(resp), .ctrl_error(ctrl_error),
    .ch_error(ch_error), .ch_health(ch_health), .bus_busy(bus_busy), .ch_irq(ch_irq),
    .read_data_valid(rvalid), .read_data(rdata), .micro(micro));

  // one-cycle pulses counted on the settled falling edge
  always @(negedge clk) begin
    if (micro.pio_req === 1'b1) npio++;
    if (micro.parity_err === 1'b1) nperr++;
  end

  // ---------------------------------
  // shared checks
  // ---------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic op(input logic [5:0] s, input logic [10:0] p, input logic oe, input logic r,
                    input logic h, input int pio);
    npio = 0;
    i_cpu_model.issue(s, p, 32'h0, 4'h0);
    repeat (4) @(negedge clk);
    chk("echo_oe", 32'(oe), 32'(resp.echo_oe));
    if (oe) chk("echo", 32'(SEL_CTRL0), 32'(resp.echo));
    if (oe) chk("echo weight", 32'(CODE_WEIGHT), 32'($countones(resp.echo)));
    chk("ready", 32'(r), 32'(resp.ready));
    chk("health_ok", 32'(h), 32'(resp.health_ok));
    chk("pio_req", 32'(pio), 32'(npio));
  endtask

  task automatic fin();
    i_cpu_model.drop();
    chk("echo_oe idle", 32'h0, 32'(resp.echo_oe));
    chk("ready idle", 32'h0, 32'(resp.ready));
  endtask

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_ctrl_all();
    for (int b = 0; b < NUM_PULSE; b++) begin
      if (b != P_UNUSED6) begin
        op(SEL_CTRL0, 11'(1 << b), 1'b1, 1'b1, 1'b1, (b == P_WRITE_CA) ? 1 : 0);
        fin();
      end
    end
  endtask

  task automatic t_chan();
    logic [5:0] cc [4] = '{SEL_C0CH0, SEL_C0CH1, SEL_C0CH2, SEL_C0CH3};
    int         pb [4] = '{P_READ_IRQ, P_READ_SVC, P_IDLE_SEQ, P_CLR_FAULT};
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        op(cc[c], 11'(1 << pb[k]), 1'b1, 1'b0, 1'b0, 1);
        fin();
      end
      op(cc[c], 11'h400, 1'b1, 1'b1, 1'b1, 1);
      chk("target_self", 32'h0, 32'(micro.target_self));
      chk("target_ch", 32'(c), 32'(micro.target_ch));
      fin();
    end
    ch_health = 4'hD;
    op(SEL_C0CH1, 11'h001, 1'b1, 1'b1, 1'b0, 0);
    fin();
    ch_health = 4'hF;
  endtask

  // foreign, slot, invalid, multi-hot, spare-bit and inhibited requests
  task automatic t_ignored();
    logic [5:0] bad [14] = '{6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19, 6'h1A,
                             6'h1C, 6'h2C, 6'h3F, 6'h24, 6'h00};
    for (int i = 0; i < 14; i++) begin
      op(bad[i], 11'h002, 1'b0, 1'b0, 1'b0, 0);
      fin();
    end
    op(SEL_CTRL0, 11'h003, 1'b0, 1'b0, 1'b0, 0);
    fin();
    op(SEL_CTRL0, 11'h040, 1'b0, 1'b0, 1'b0, 0);
    fin();
    i_cpu_model.set_inhibit(1'b1);
    op(SEL_CTRL0, 11'h002, 1'b0, 1'b0, 1'b0, 0);
    fin();
    i_cpu_model.set_inhibit(1'b0);
  endtask

  task automatic t_fault_irq();
    ch_error = 4'h4;
    ch_irq = 4'h4;
    op(SEL_CTRL0, 11'h002, 1'b1, 1'b1, 1'b0, 0);
    chk("fault", 32'h1, 32'(resp.fault));
    chk("irq", 32'h2, 32'(resp.irq));
    fin();
    ch_error = 4'h0;
    ctrl_error = 1'b1;
    ch_irq = 4'h3;
    op(SEL_CTRL0, 11'h002, 1'b1, 1'b1, 1'b0, 0);
    chk("fault", 32'h1, 32'(resp.fault));
    chk("irq", 32'h1, 32'(resp.irq));
    fin();
    ctrl_error = 1'b0;
    ch_irq = 4'h0;
    repeat (2) @(negedge clk);
    chk("fault clear", 32'h0, 32'(resp.fault));
    chk("irq clear", 32'h0, 32'(resp.irq));
  endtask

  // read waits for data and a quiet bus
  task automatic t_read();
    bus_busy = 1'b1;
    op(SEL_CTRL0, 11'h002, 1'b1, 1'b0, 1'b1, 0);
    bus_busy = 1'b0;
    repeat (2) @(negedge clk);
    chk("ready after busy", 32'h1, 32'(resp.ready));
    fin();
    bus_busy = 1'b1;
    rvalid = 1'b0;
    rdata = 32'h0102_03F0;
    op(SEL_CTRL0, 11'h001, 1'b1, 1'b0, 1'b1, 0);
    bus_busy = 1'b0;
    repeat (3) @(negedge clk);
    chk("ready no data", 32'h0, 32'(resp.ready));
    chk("data_oe", 32'h0, 32'(doe));
    rvalid = 1'b1;
    repeat (3) @(negedge clk);
    chk("ready", 32'h1, 32'(resp.ready));
    chk("data_out", rdata, dout);
    chk("parity_out", 32'({^rdata[31:24], ^rdata[23:16], ^rdata[15:8], ^rdata[7:0]}), 32'(pout));
    fin();
    chk("data_oe idle", 32'h0, 32'(doe));
  endtask

  task automatic t_parity();
    nperr = 0;
    i_cpu_model.issue(SEL_CTRL0, 11'h200, 32'h0000_00FF, 4'h1);
    repeat (4) @(negedge clk);
    chk("wdata", 32'h0000_00FF, micro.wdata);
    chk("op", 32'h0000_0200, 32'(micro.op));
    chk("target_self", 32'h1, 32'(micro.target_self));
    i_cpu_model.drop();
    chk("parity_err bad", 32'h1, 32'(nperr));
    i_cpu_model.issue(SEL_CTRL0, 11'h400, 32'h0000_01FF, 4'h2);
    repeat (4) @(negedge clk);
    chk("wdata", 32'h0000_01FF, micro.wdata);
    i_cpu_model.drop();
    chk("parity_err good", 32'h1, 32'(nperr));
  endtask

  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_ctrl_all();
    t_chan();
    t_ignored();
    t_fault_irq();
    t_read();
    t_parity();
    give_verdict();
  end

  // hang guard, about twenty times the expected run
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
